/* rtl/lsba_alu.sv */
// Purpose: logic, shift/rotate and bit-manipulation datapath of the core
// Assumes: core holds i_req stable only in the accept cycle
// Notes:   memory bit operands use a byte read-modify-write port
// Operation
// - logic and shift take byte, word, long; bit operations are byte only
// - and combines destination with register or immediate, writes destination
// - or combines destination with register or immediate, writes destination
// - xor combines destination with register or immediate, writes destination
// - not inverts every bit of the sized destination
// - arithmetic shifts move destination one place, right keeps sign
// - logic shifts move destination one place, fill with zero
// - rotates move destination one place, out bit re-enters opposite end
// - rotates through carry include carry in the loop
// - bit set forces the selected byte bit to one
// - bit clear forces the selected byte bit to zero
// - bit invert toggles the selected bit, writes the byte back
// - bit test sets zero flag to inverse of bit, operand unchanged
// - set, clear, invert, test take bit number from immediate or register
// - carry bit operations, plain and inverted, take bit number from immediate only
// - carry becomes carry and bit, or carry and inverted bit
// - carry becomes carry or bit, or carry or inverted bit
// - carry becomes carry xor bit, or carry xor inverted bit
// - carry becomes selected bit, or its inverse
// - selected bit becomes carry, or inverted carry, others unchanged
`timescale 1ns/1ns
`default_nettype none
module lsba_alu (
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_reset,
    input  wire logic                  i_valid,
    input  wire lsba_pkg::lsba_req_s   i_req,
    input  wire lsba_pkg::lsba_flags_s i_flags,
    input  wire logic [7:0]            i_mem_rdata,
    input  wire logic                  i_mem_ack,
    output logic                       o_ready,
    output logic                       o_done,
    output logic [31:0]                o_result,
    output logic                       o_result_we,
    output lsba_pkg::lsba_flags_s      o_flags,
    output lsba_pkg::lsba_flags_s      o_flags_we,
    output logic                       o_mem_rd,
    output logic                       o_mem_wr,
    output logic [15:0]                o_mem_addr,
    output logic [7:0]                 o_mem_wdata
);

    // ************************************************************
    // state and captured request
    // ************************************************************
    typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_EXEC, ST_WR} lsba_state_e;

    lsba_state_e           state;
    lsba_pkg::lsba_req_s   req_q;
    lsba_pkg::lsba_flags_s cc_q;
    logic                  mem_q;
    logic [7:0]            mem_byte;
    logic                  mem_req;
    logic                  accept;

    // datapath values
    logic [31:0]           src_val;
    logic [31:0]           opnd;
    logic [2:0]            bit_no;
    logic                  bit_val;
    logic [7:0]            bmask;
    logic [7:0]            nbyte;
    logic [31:0]           lres;
    logic [31:0]           mres;
    logic [31:0]           mask;
    logic                  wb;
    logic                  is_bit;
    logic                  imm_only;
    lsba_pkg::lsba_size_e  eff_size;
    lsba_pkg::lsba_flags_s nflags;
    lsba_pkg::lsba_flags_s nwe;
    logic [31:0]           sh_res;
    logic                  sh_c;
    logic                  ex_reg;

    // only bit operations may address memory
    assign mem_req = i_req.mem_operand && (i_req.op >= lsba_pkg::OP_BIT_SET_OP);
    assign accept  = i_valid && (state == ST_IDLE);
    assign o_ready = (state == ST_IDLE);
    assign ex_reg  = (state == ST_EXEC) && !mem_q;

    // ************************************************************
    // sequencer
    // ************************************************************
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: if (accept) begin
                    state <= mem_req ? ST_RD : ST_EXEC;
                end
                ST_RD: if (i_mem_ack) begin
                    state <= ST_EXEC;
                end
                ST_EXEC: state <= (mem_q && wb) ? ST_WR : ST_IDLE;
                ST_WR: if (i_mem_ack) begin
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // request, flags and memory byte capture
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            req_q    <= '0;
            cc_q     <= lsba_pkg::FLAGS_RST;
            mem_q    <= 1'b0;
            mem_byte <= 8'h00;
        end else begin
            if (accept) begin
                req_q <= i_req;
                cc_q  <= i_flags;
                mem_q <= mem_req;
            end
            if (state == ST_RD && i_mem_ack) begin
                mem_byte <= i_mem_rdata;
            end
        end
    end

    // ************************************************************
    // datapath
    // ************************************************************
    lsba_shifter u_shifter (
        .i_op     (req_q.op),
        .i_size   (req_q.size),
        .i_value  (req_q.dst),
        .i_carry  (cc_q.c),
        .o_result (sh_res),
        .o_carry  (sh_c)
    );

    // operand selection and bit addressing
    always_comb begin
        is_bit   = (req_q.op >= lsba_pkg::OP_BIT_SET_OP);
        imm_only = (req_q.op >= lsba_pkg::OP_BIT_AND_CARRY);
        eff_size = is_bit ? lsba_pkg::SZ_BYTE : req_q.size;
        src_val  = req_q.src_imm ? req_q.imm : req_q.src_reg;
        opnd     = mem_q ? {24'h000000, mem_byte} : req_q.dst;
        if (req_q.bit_from_reg && !imm_only) begin
            bit_no = req_q.src_reg[2:0];
        end else begin
            bit_no = req_q.imm[2:0];
        end
        bit_val = opnd[bit_no];
        bmask   = 8'(8'h01 << bit_no);
        case (eff_size)
            lsba_pkg::SZ_BYTE: mask = lsba_pkg::MASK_BYTE;
            lsba_pkg::SZ_WORD: mask = lsba_pkg::MASK_WORD;
            default:           mask = lsba_pkg::MASK_LONG;
        endcase
    end

    // operation results, write-back and flag updates
    always_comb begin
        lres   = opnd;
        nbyte  = opnd[7:0];
        wb     = 1'b1;
        nflags = cc_q;
        nwe    = 3'h0;
        case (req_q.op)
            lsba_pkg::OP_AND: lres = opnd & src_val;
            lsba_pkg::OP_OR:  lres = opnd | src_val;
            lsba_pkg::OP_XOR: lres = opnd ^ src_val;
            lsba_pkg::OP_NOT: lres = ~opnd;
            lsba_pkg::OP_BIT_SET_OP:   nbyte = opnd[7:0] | bmask;
            lsba_pkg::OP_BIT_CLEAR_OP: nbyte = opnd[7:0] & ~bmask;
            lsba_pkg::OP_BIT_INVERT:   nbyte = opnd[7:0] ^ bmask;
            lsba_pkg::OP_BIT_TEST: begin
                wb       = 1'b0;
                nflags.z = ~bit_val;
                nwe.z    = 1'b1;
            end
            lsba_pkg::OP_BIT_STORE_CARRY:
                nbyte = (opnd[7:0] & ~bmask) | (cc_q.c ? bmask : 8'h00);
            lsba_pkg::OP_INV_BIT_STORE_CARRY:
                nbyte = (opnd[7:0] & ~bmask) | (cc_q.c ? 8'h00 : bmask);
            default: begin
                if (req_q.op >= lsba_pkg::OP_BIT_AND_CARRY) begin
                    wb    = 1'b0;
                    nwe.c = 1'b1;
                end else begin
                    lres  = sh_res;
                    nwe.c = 1'b1;
                end
            end
        endcase
        // carry combining and loading group
        case (req_q.op)
            lsba_pkg::OP_BIT_AND_CARRY:      nflags.c = cc_q.c & bit_val;
            lsba_pkg::OP_BIT_INV_AND_CARRY:  nflags.c = cc_q.c & ~bit_val;
            lsba_pkg::OP_BIT_OR_CARRY:       nflags.c = cc_q.c | bit_val;
            lsba_pkg::OP_BIT_INV_OR_CARRY:   nflags.c = cc_q.c | ~bit_val;
            lsba_pkg::OP_BIT_XOR_CARRY:      nflags.c = cc_q.c ^ bit_val;
            lsba_pkg::OP_BIT_INV_XOR_CARRY:  nflags.c = cc_q.c ^ ~bit_val;
            lsba_pkg::OP_BIT_LOAD_CARRY:     nflags.c = bit_val;
            lsba_pkg::OP_INV_BIT_LOAD_CARRY: nflags.c = ~bit_val;
            default: begin
                if (!is_bit) begin
                    nflags.c = nwe.c ? sh_c : cc_q.c;
                end
            end
        endcase
        if (is_bit) begin
            lres = {opnd[31:8], nbyte};
        end
        // merge sized part into destination, upper bits kept
        mres = (req_q.dst & ~mask) | (lres & mask);
        if (!is_bit) begin
            nflags.n = |(mres & mask & ~(mask >> 1));
            nflags.z = ((mres & mask) == 32'h00000000);
            nwe.n    = 1'b1;
            nwe.z    = 1'b1;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // result and flag write strobes for one cycle
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_result    <= 32'h00000000;
            o_result_we <= 1'b0;
            o_flags     <= lsba_pkg::FLAGS_RST;
            o_flags_we  <= lsba_pkg::FLAGS_RST;
        end else begin
            o_result_we <= ex_reg && wb;
            o_flags_we  <= (state == ST_EXEC) ? nwe : 3'h0;
            if (state == ST_EXEC) begin
                o_result <= mres;
                o_flags  <= nflags;
            end
        end
    end

    // completion pulse
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_done <= 1'b0;
        end else begin
            o_done <= ((state == ST_EXEC) && !(mem_q && wb))
                   || ((state == ST_WR) && i_mem_ack);
        end
    end

    // memory read-modify-write port, strobes held until ack
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_mem_rd    <= 1'b0;
            o_mem_wr    <= 1'b0;
            o_mem_addr  <= 16'h0000;
            o_mem_wdata <= 8'h00;
        end else begin
            if (accept && mem_req) begin
                o_mem_rd   <= 1'b1;
                o_mem_addr <= i_req.mem_addr;
            end else if (state == ST_RD && i_mem_ack) begin
                o_mem_rd <= 1'b0;
            end
            if (state == ST_EXEC && mem_q && wb) begin
                o_mem_wr    <= 1'b1;
                o_mem_wdata <= nbyte;
            end else if (state == ST_WR && i_mem_ack) begin
                o_mem_wr <= 1'b0;
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    and_result_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        ex_reg && req_q.op == lsba_pkg::OP_AND && req_q.size == lsba_pkg::SZ_BYTE
        |=> o_result_we && o_result[7:0] == ($past(opnd[7:0]) & $past(src_val[7:0])))
        else $error("and result wrong");

    or_result_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        ex_reg && req_q.op == lsba_pkg::OP_OR && req_q.size == lsba_pkg::SZ_WORD
        |=> o_result[15:0] == ($past(opnd[15:0]) | $past(src_val[15:0])))
        else $error("or result wrong");

    xor_result_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        ex_reg && req_q.op == lsba_pkg::OP_XOR && req_q.size == lsba_pkg::SZ_LONG
        |=> o_result == ($past(opnd) ^ $past(src_val)))
        else $error("xor result wrong");

    not_result_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        ex_reg && req_q.op == lsba_pkg::OP_NOT && req_q.size == lsba_pkg::SZ_BYTE
        |=> o_result[7:0] == ~$past(opnd[7:0]) && o_result[31:8] == $past(opnd[31:8]))
        else $error("not result wrong");

    sar_sign_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        ex_reg && req_q.op == lsba_pkg::OP_ARITHMETIC_SHIFT_RIGHT
        && req_q.size == lsba_pkg::SZ_BYTE
        |=> o_result[7:6] == {2{$past(opnd[7])}} && o_flags.c == $past(opnd[0]))
        else $error("arithmetic right shift wrong");

    shr_fill_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        ex_reg && req_q.op == lsba_pkg::OP_LOGIC_SHIFT_RIGHT
        && req_q.size == lsba_pkg::SZ_WORD
        |=> !o_result[15] && !o_flags.n && o_flags_we == 3'h7)
        else $error("logic right shift fill wrong");

    rotate_left_wrap_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        ex_reg && req_q.op == lsba_pkg::OP_ROTATE_LEFT && req_q.size == lsba_pkg::SZ_BYTE
        |=> o_result[0] == $past(opnd[7]) && o_flags.c == $past(opnd[7]))
        else $error("rotate left wrap wrong");

    rotate_through_carry_right_carry_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        ex_reg && req_q.op == lsba_pkg::OP_ROTATE_THROUGH_CARRY_RIGHT
        && req_q.size == lsba_pkg::SZ_LONG
        |=> o_result[31] == $past(cc_q.c) && o_flags.c == $past(opnd[0]))
        else $error("rotate through carry wrong");

    bit_test_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        state == ST_EXEC && req_q.op == lsba_pkg::OP_BIT_TEST
        |=> o_flags.z == !$past(bit_val) && !o_result_we && !o_mem_wr)
        else $error("bit test wrong");

    imm_bitno_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        state == ST_EXEC && req_q.op == lsba_pkg::OP_BIT_LOAD_CARRY
        |=> o_flags.c == $past(opnd[req_q.imm[2:0]]) && o_flags_we == 3'h1)
        else $error("carry bit op used register bit number");

    bit_clear_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        ex_reg && req_q.op == lsba_pkg::OP_BIT_CLEAR_OP
        |=> o_result_we && !o_result[$past(bit_no)] && o_result[31:8] == $past(req_q.dst[31:8]))
        else $error("bit clear result wrong");

    bit_invert_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        ex_reg && req_q.op == lsba_pkg::OP_BIT_INVERT
        |=> o_result[$past(bit_no)] == !$past(bit_val) && o_result[31:8] == $past(req_q.dst[31:8]))
        else $error("bit invert result wrong");

    mem_rmw_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        state == ST_RD && i_mem_ack && req_q.op == lsba_pkg::OP_BIT_SET_OP
        |=> ##1 o_mem_wr && o_mem_wdata == ($past(i_mem_rdata, 2) | $past(bmask)))
        else $error("memory bit write-back wrong");

endmodule
`default_nettype wire

/* pkg/lsba_pkg.sv */
// Purpose: shared types and constants of the logic, shift and bit alu
// Assumes: one core clock, synchronous active-high reset
// Notes:   requests and flags travel as packed structs
package lsba_pkg;

    // ************************************************************
    // widths and masks
    // ************************************************************
    localparam int          DATA_W    = 32;
    localparam int          ADDR_W    = 16;
    localparam int          BITNO_W   = 3;
    localparam int          BYTE_W    = 8;
    localparam logic [31:0] MASK_BYTE = 32'h000000FF;
    localparam logic [31:0] MASK_WORD = 32'h0000FFFF;
    localparam logic [31:0] MASK_LONG = 32'hFFFFFFFF;
    localparam logic [4:0]  MSB_BYTE  = 5'h07;
    localparam logic [4:0]  MSB_WORD  = 5'h0F;
    localparam logic [4:0]  MSB_LONG  = 5'h1F;

    // ************************************************************
    // operations and sizes
    // ************************************************************
    typedef enum logic [4:0] {
        OP_AND,
        OP_OR,
        OP_XOR,
        OP_NOT,
        OP_ARITHMETIC_SHIFT_LEFT,
        OP_ARITHMETIC_SHIFT_RIGHT,
        OP_LOGIC_SHIFT_LEFT,
        OP_LOGIC_SHIFT_RIGHT,
        OP_ROTATE_LEFT,
        OP_ROTATE_RIGHT,
        OP_ROTATE_THROUGH_CARRY_LEFT,
        OP_ROTATE_THROUGH_CARRY_RIGHT,
        OP_BIT_SET_OP,
        OP_BIT_CLEAR_OP,
        OP_BIT_INVERT,
        OP_BIT_TEST,
        OP_BIT_AND_CARRY,
        OP_BIT_INV_AND_CARRY,
        OP_BIT_OR_CARRY,
        OP_BIT_INV_OR_CARRY,
        OP_BIT_XOR_CARRY,
        OP_BIT_INV_XOR_CARRY,
        OP_BIT_LOAD_CARRY,
        OP_INV_BIT_LOAD_CARRY,
        OP_BIT_STORE_CARRY,
        OP_INV_BIT_STORE_CARRY
    } lsba_op_e;

    typedef enum logic [1:0] {
        SZ_BYTE,
        SZ_WORD,
        SZ_LONG
    } lsba_size_e;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic n;
        logic z;
        logic c;
    } lsba_flags_s;

    typedef struct packed {
        lsba_op_e          op;
        lsba_size_e        size;
        logic              src_imm;      // second operand from imm
        logic              bit_from_reg; // bit number from src_reg[2:0], set/clear/invert/test only
        logic              mem_operand;  // bit op works on a memory byte
        logic [ADDR_W-1:0] mem_addr;
        logic [DATA_W-1:0] dst;
        logic [DATA_W-1:0] src_reg;
        logic [DATA_W-1:0] imm;
    } lsba_req_s;

    localparam lsba_flags_s FLAGS_RST = 3'h0;

endpackage

/* rtl/lsba_shifter.sv */
// Purpose: one-place shift and rotate of a byte, word or longword
// Assumes: op is one of the eight shift or rotate operations
// Notes:   bits above the operand size are don't-care on the output
`timescale 1ns/1ns
`default_nettype none
module lsba_shifter (
    input  wire lsba_pkg::lsba_op_e   i_op,
    input  wire lsba_pkg::lsba_size_e i_size,
    input  wire logic [31:0]          i_value,
    input  wire logic                 i_carry,
    output logic [31:0]               o_result,
    output logic                      o_carry
);

    logic [4:0]  msb;
    logic        top_bit;
    logic        is_left;
    logic        fill;
    logic [31:0] right;

    // index of the sign bit for the operand size
    always_comb begin
        case (i_size)
            lsba_pkg::SZ_BYTE: msb = lsba_pkg::MSB_BYTE;
            lsba_pkg::SZ_WORD: msb = lsba_pkg::MSB_WORD;
            default:           msb = lsba_pkg::MSB_LONG;
        endcase
    end

    assign top_bit = i_value[msb];

    // direction and the bit that enters the vacated end
    always_comb begin
        is_left = 1'b1;
        fill    = 1'b0;
        case (i_op)
            lsba_pkg::OP_ROTATE_LEFT:                fill = top_bit;
            lsba_pkg::OP_ROTATE_THROUGH_CARRY_LEFT:  fill = i_carry;
            lsba_pkg::OP_ARITHMETIC_SHIFT_RIGHT: begin
                is_left = 1'b0;
                fill    = top_bit;
            end
            lsba_pkg::OP_LOGIC_SHIFT_RIGHT:          is_left = 1'b0;
            lsba_pkg::OP_ROTATE_RIGHT: begin
                is_left = 1'b0;
                fill    = i_value[0];
            end
            lsba_pkg::OP_ROTATE_THROUGH_CARRY_RIGHT: begin
                is_left = 1'b0;
                fill    = i_carry;
            end
            default: ;
        endcase
    end

    // move by one place; the bit pushed out goes to carry
    always_comb begin
        right      = {1'b0, i_value[31:1]};
        right[msb] = fill;
        o_result   = is_left ? {i_value[30:0], fill} : right;
        o_carry    = is_left ? top_bit : i_value[0];
    end

endmodule
`default_nettype wire

/* tb/lsba_alu_bench.sv */
// Purpose: self-checking bench of the logic, shift and bit alu
// Assumes: synchronous active-high reset, memory port answered by the bench
// Notes:   random requests from an xorshift source, checked against a model
`timescale 1ns/1ns
`default_nettype none
module lsba_alu_bench;
    // ************************************************************
    // clock, stimulus and design
    // ************************************************************
    logic                  i_sys_clk   = 1'b0;
    logic                  i_reset     = 1'b1;
    logic                  i_valid     = 1'b0;
    lsba_pkg::lsba_req_s   i_req       = '0;
    lsba_pkg::lsba_flags_s i_flags     = '0;
    logic [7:0]            i_mem_rdata = 8'h00;
    logic                  i_mem_ack   = 1'b0;
    logic                  o_ready, o_done, o_result_we, o_mem_rd, o_mem_wr;
    logic [31:0]           o_result;
    lsba_pkg::lsba_flags_s o_flags, o_flags_we;
    logic [15:0]           o_mem_addr;
    logic [7:0]            o_mem_wdata, mem_byte;
    logic [15:0]           exp_addr;
    logic [7:0]            wr_q[$];
    logic [31:0]           seed = 32'd97161;
    int                    error_cnt = 0, n_tests = 0, stall = 0;

    always #5 i_sys_clk = ~i_sys_clk;

    lsba_alu lsba_alu_i (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_valid(i_valid),
        .i_req(i_req), .i_flags(i_flags), .i_mem_rdata(i_mem_rdata), .i_mem_ack(i_mem_ack),
        .o_ready(o_ready), .o_done(o_done), .o_result(o_result), .o_result_we(o_result_we),
        .o_flags(o_flags), .o_flags_we(o_flags_we), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
        .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata));

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // memory partner: acks after a random stall, toggles the byte off the ack
    always @(posedge i_sys_clk) begin
        i_mem_rdata <= ~i_mem_rdata;
        i_mem_ack   <= 1'b0;
        if (i_mem_ack === 1'b1 && o_mem_wr === 1'b1) begin
            wr_q.push_back(o_mem_wdata);
        end
        if (i_mem_ack === 1'b1) chk(o_mem_addr === exp_addr, "memory address");
        if (!i_mem_ack && (o_mem_rd || o_mem_wr) && stall == 0) begin
            i_mem_ack <= 1'b1;
            stall     <= int'(xs() % 3);
            if (o_mem_rd) i_mem_rdata <= mem_byte;
        end else if (stall != 0) begin
            stall <= stall - 1;
        end
    end

    // reference model: result, new flags, flag mask, write-back expected
    task automatic model(input lsba_pkg::lsba_req_s q, input lsba_pkg::lsba_flags_s f,
        input logic [31:0] v, output logic [31:0] r, output lsba_pkg::lsba_flags_s nf,
        output logic [2:0] we, output logic wr);
        int          op, msb;
        logic [31:0] m, s;
        logic [2:0]  b;
        op  = int'(q.op);
        msb = q.size == lsba_pkg::SZ_BYTE ? 7 : (q.size == lsba_pkg::SZ_WORD ? 15 : 31);
        if (op >= 12) msb = 7;
        m  = msb == 31 ? 32'hFFFFFFFF : (32'h1 << (msb + 1)) - 32'h1;
        s  = q.src_imm ? q.imm : q.src_reg;
        b  = (q.bit_from_reg && op <= 15) ? q.src_reg[2:0] : q.imm[2:0];
        r  = v;
        nf = f;
        we = 3'h0;
        wr = 1'b1;
        case (op)
            0: r = v & s;
            1: r = v | s;
            2: r = v ^ s;
            3: r = ~v;
            4, 6: begin r = v << 1; nf.c = v[msb]; end
            5: begin r = v >> 1; r[msb] = v[msb]; nf.c = v[0]; end
            7: begin r = (v & m) >> 1; nf.c = v[0]; end
            8: begin r = v << 1; r[0] = v[msb]; nf.c = v[msb]; end
            9: begin r = (v & m) >> 1; r[msb] = v[0]; nf.c = v[0]; end
            10: begin r = v << 1; r[0] = f.c; nf.c = v[msb]; end
            11: begin r = (v & m) >> 1; r[msb] = f.c; nf.c = v[0]; end
            12: r[b] = 1'b1;
            13: r[b] = 1'b0;
            14: r[b] = ~v[b];
            15: nf.z = ~v[b];
            16: nf.c = f.c & v[b];
            17: nf.c = f.c & ~v[b];
            18: nf.c = f.c | v[b];
            19: nf.c = f.c | ~v[b];
            20: nf.c = f.c ^ v[b];
            21: nf.c = f.c ^ ~v[b];
            22: nf.c = v[b];
            23: nf.c = ~v[b];
            24: r[b] = f.c;
            default: r[b] = ~f.c;
        endcase
        if (op <= 11) begin
            nf.n = r[msb];
            nf.z = (r & m) == 32'h0;
            we   = op <= 3 ? 3'h6 : 3'h7;
        end else if (op == 15) begin
            we = 3'h2;
            wr = 1'b0;
        end else if (op >= 16 && op <= 23) begin
            we = 3'h1;
            wr = 1'b0;
        end
        r = (v & ~m) | (r & m);
    endtask

    // one request: issue, wait for done, compare with the model
    task automatic run(input lsba_pkg::lsba_req_s q, input lsba_pkg::lsba_flags_s f);
        logic [31:0]           er, gr;
        lsba_pkg::lsba_flags_s ef, gf;
        logic [2:0]            ewe, gwe;
        logic                  ewr, gw, gd, mem;
        mem = q.mem_operand && int'(q.op) >= 12;
        model(q, f, mem ? {24'h0, mem_byte} : q.dst, er, ef, ewe, ewr);
        gwe      = 3'h0;
        gw       = 1'b0;
        gd       = 1'b0;
        gr       = 32'h0;
        gf       = '0;
        wr_q.delete();
        exp_addr = q.mem_addr;
        @(posedge i_sys_clk);
        i_valid <= 1'b1;
        i_req   <= q;
        i_flags <= f;
        @(posedge i_sys_clk);
        i_valid <= 1'b0;
        i_req   <= ~q;
        i_flags <= ~f;
        for (int k = 0; k < 40 && !gd; k++) begin
            #1;
            if (o_flags_we !== 3'h0) begin gwe = o_flags_we; gf = o_flags; end
            if (o_result_we === 1'b1) begin gw = 1'b1; gr = o_result; end
            gd = o_done === 1'b1;
            if (!gd) @(posedge i_sys_clk);
        end
        chk(gd && o_ready === 1'b1, "no done");
        chk(gwe === ewe && (ewe == 3'h0 || gf === ef), "flags");
        if (mem) begin
            chk(!gw && (ewr ? wr_q.size() == 1 && wr_q[0] === er[7:0] : wr_q.size() == 0), "memory byte");
            mem_byte = er[7:0];
        end else begin
            chk(ewr ? gw && gr === er : (!gw || gr === er), "result");
        end
    endtask

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        lsba_pkg::lsba_req_s q;
        logic [31:0]         x;
        mem_byte = 8'h5A;
        repeat (3) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        #1;
        chk(o_ready === 1'b1 && o_done === 1'b0 && o_result_we === 1'b0
            && o_mem_rd === 1'b0 && o_mem_wr === 1'b0, "reset state");
        $display("test reset finished");
        // every operation at every size, sign and end bits set on the first pass
        for (int rep = 0; rep < 8; rep++) begin
            for (int op = 0; op < 26; op++) begin
                for (int sz = 0; sz < 3; sz++) begin
                    x              = xs();
                    q.op           = lsba_pkg::lsba_op_e'(op);
                    q.size         = lsba_pkg::lsba_size_e'(sz);
                    q.src_imm      = x[0];
                    q.bit_from_reg = x[1];
                    q.mem_operand  = x[2];
                    q.mem_addr     = x[31:16];
                    q.dst          = rep == 0 ? 32'h80008081 : xs();
                    q.src_reg      = xs();
                    q.imm          = xs();
                    run(q, lsba_pkg::lsba_flags_s'(x[5:3]));
                end
            end
        end
        $display("test operations finished");
        end_sim();
    end

    // watchdog well beyond the expected run length
    initial begin
        #300000;
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_sim();
    end
endmodule
`default_nettype wire
